// [hw/instr_modify_pkg.sv]
// constants, field layout and types for the instruction address modifier
package instr_modify_pkg;
  // ----------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 48;
  localparam int HALF_W = 24;
  localparam int ADDR_W_DEF = 15;
  localparam int V_W_DEF = 12;
  localparam int RPT_CNT_W = 12;
  localparam logic [11:0] RPT_MAX = 12'hfff;
  localparam int S_BIT = 23;
  localparam int CMD_HI = 22;
  localparam int CMD_LO = 17;
  localparam int F_BIT = 16;
  localparam int LONG_HI = 23;
  localparam int LONG_LO = 16;
  localparam int RPT_L_HI = 23;
  localparam int RPT_L_LO = 22;
  localparam int RPT_R_HI = 21;
  localparam int RPT_R_LO = 20;
  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [5:0] OP_NOP = 6'h00;
  localparam logic [5:0] OP_JMP = 6'h01;
  localparam logic [5:0] OP_TIJ = 6'h02;
  localparam logic [5:0] OP_TJM = 6'h03;
  localparam logic [5:0] OP_MEMORY_ADDRESS_INCREMENT = 6'h04;
  localparam logic [5:0] OP_ARITH = 6'h05;
  localparam logic [5:0] OP_INDEX = 6'h06;
  localparam logic [5:0] OP_HLT = 6'h08;
  localparam logic [2:0] RPT_LOW3 = 3'h7;
  localparam logic [7:0] OP_EXT_INS = 8'h78;
  localparam logic [7:0] OP_EXT_CLR = 8'h79;
  // ----------------------------------------------------------------
  // register map (byte offsets) and bits
  // ----------------------------------------------------------------
  localparam int AXI_AW = 8;
  localparam logic [7:0] REG_INSTR = 8'h00;
  localparam logic [7:0] REG_LOC = 8'h04;
  localparam logic [7:0] REG_JA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_DECODE = 8'h10;
  localparam int POS_BIT = 24;
  localparam int JA_F_BIT = 16;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MOD_NONE = 2'h0,
    MOD_ADD = 2'h1,
    MOD_SUB = 2'h2
  } rpt_mod_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_READ = 3'h1,
    ST_INCR = 3'h3,
    ST_MERGE = 3'h2,
    ST_WRITE = 3'h6
  } exec_state_e;
endpackage

// [hw/instruction_address_modify.sv]
// instruction address modifier: substitution, increment and mode decode
//
// How it works
// RULE1: repeat bits a,b steer left half, c,d right: 0x none, 10 add, 11 sub.
// RULE2: repeat's first mode bit doubles as its address-size select bit.
// RULE3: substitution copies reduced field if target S is 1, else full width.
// RULE4: repeat count is a twelve-bit field, at most 4095.
// RULE5: substitution also copies the jump register flag into the target.
// RULE6: jump sets jump register flag to next half if no jump: 0 left.
// RULE7: instruction-address-to-jump-register copies its own flag into flag.
// RULE8: arithmetic flag 0 selects fixed point, 1 floating point.
// RULE9: jump flag picks target half; index flag picks right half/counter.
// RULE10: repeat, stop and no-operation ignore their mode flag.
// RULE11: extract commands decode from eight bits including the flag.
// RULE12: address increment adds one to stored instruction address field.
// RULE13: increment reads word, sets jump register, merges back, writes.
// RULE14: increment touches only the selected half and keeps its flag.
// RULE15: increment width is reduced field if S is 1, else full address.
// RULE16: repeat instructions take no index register modification.
// RULE17: left repeat repeats one instruction, right repeat a pair.
// RULE18: repeat mode leaves, increments or decrements index per half.
module instruction_address_modify #(
  parameter int ADDR_W = instr_modify_pkg::ADDR_W_DEF,
  parameter int V_W = instr_modify_pkg::V_W_DEF
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [instr_modify_pkg::AXI_AW-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [instr_modify_pkg::AXI_AW-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic [instr_modify_pkg::WORD_W-1:0] o_mem_wdata,
  input wire logic [instr_modify_pkg::WORD_W-1:0] i_mem_rdata,
  input wire logic i_mem_ack
);
  import instr_modify_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  exec_state_e state_reg, state_next;
  logic [HALF_W-1:0] instr_reg;
  logic pos_reg;
  logic start_reg;
  logic [ADDR_W-1:0] loc_reg;
  logic [ADDR_W-1:0] ja_addr_reg, ja_addr_next;
  logic ja_f_reg, ja_f_next;
  logic [WORD_W-1:0] oper_reg, oper_next;
  logic [ADDR_W-1:0] mem_addr_reg;
  logic done_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;

  localparam logic [ADDR_W-1:0] FULL_MASK = {ADDR_W{1'b1}};
  localparam logic [ADDR_W-1:0] V_MASK =
    {{(ADDR_W-V_W){1'b0}}, {V_W{1'b1}}};

  function automatic logic [31:0] merge32(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic rpt_mod_e mod_of(input logic [1:0] bits);
    return bits[1] ? (bits[0] ? MOD_SUB : MOD_ADD) : MOD_NONE;
  endfunction

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  wire [5:0] op = instr_reg[CMD_HI:CMD_LO];
  wire [7:0] long_op = instr_reg[LONG_HI:LONG_LO];
  wire f_bit = instr_reg[F_BIT];
  // RULE2: repeat first mode bit is S
  wire s_bit = instr_reg[S_BIT];
  // RULE11: extract uses the long code
  wire is_ext = (long_op == OP_EXT_INS) || (long_op == OP_EXT_CLR);
  wire is_rpt = !is_ext && (op[2:0] == RPT_LOW3);
  wire plain = !is_ext && !is_rpt;
  wire is_jmp = plain && (op == OP_JMP);
  wire is_tij = plain && (op == OP_TIJ);
  wire is_tjm = plain && (op == OP_TJM);
  wire is_memory_address_increment = plain && (op == OP_MEMORY_ADDRESS_INCREMENT);
  wire is_arith = plain && (op == OP_ARITH);
  wire is_index = plain && (op == OP_INDEX);
  // RULE10: flag excluded from these codes
  wire mode_ignored = is_rpt || (plain && (op == OP_HLT || op == OP_NOP));
  wire mem_op = is_tjm || is_memory_address_increment;
  wire [ADDR_W-1:0] own_mask = s_bit ? V_MASK : FULL_MASK;
  wire [ADDR_W-1:0] own_addr = instr_reg[ADDR_W-1:0] & own_mask;
  // RULE1: pairs a,b and c,d
  wire rpt_mod_e left_mode = mod_of(instr_reg[RPT_L_HI:RPT_L_LO]);
  wire rpt_mod_e right_mode = mod_of(instr_reg[RPT_R_HI:RPT_R_LO]);
  // RULE4: twelve-bit count field
  wire [RPT_CNT_W-1:0] rpt_count = instr_reg[RPT_CNT_W-1:0];
  // RULE8: fixed or floating
  wire float_mode = is_arith && f_bit;
  // RULE9: target half, index half or counter
  wire jump_right = is_jmp && f_bit;
  wire index_right = is_index && f_bit;
  // RULE16: repeat is never indexed
  wire indexable = !is_rpt;
  // RULE17: right repeat covers a pair
  wire rpt_pair = is_rpt && pos_reg;
  // RULE18: index step of the active half
  wire rpt_mod_e active_mode = pos_reg ? right_mode : left_mode;

  // ----------------------------------------------------------------
  // target half arithmetic
  // ----------------------------------------------------------------
  // RULE14: qualifier picks the half
  wire [HALF_W-1:0] tgt_half = f_bit ? oper_reg[HALF_W-1:0]
                                     : oper_reg[WORD_W-1:HALF_W];
  // RULE3: field width from target S
  wire [ADDR_W-1:0] tgt_mask = tgt_half[S_BIT] ? V_MASK : FULL_MASK;
  wire [ADDR_W-1:0] tgt_addr = tgt_half[ADDR_W-1:0];
  // RULE15: increment within the field
  wire [ADDR_W-1:0] inc_field = (tgt_addr + ADDR_W'(1)) & tgt_mask;
  wire [ADDR_W-1:0] merged_addr =
    (tgt_addr & ~tgt_mask) | (ja_addr_reg & tgt_mask);
  // RULE5: substitution replaces the flag; increment keeps it
  wire merged_f = is_tjm ? ja_f_reg : tgt_half[F_BIT];
  wire [HALF_W-1:0] new_half = {tgt_half[HALF_W-1:F_BIT+1], merged_f,
    tgt_half[F_BIT-1:ADDR_W], merged_addr};
  wire [WORD_W-1:0] new_word = f_bit
    ? {oper_reg[WORD_W-1:HALF_W], new_half}
    : {new_half, oper_reg[HALF_W-1:0]};

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire busy = (state_reg != ST_IDLE) || start_reg;
  wire wr_take = i_awvalid && i_wvalid && !bvalid_reg;
  wire rd_take = i_arvalid && !rvalid_reg;
  // instruction, location and jump register writes are refused while a command runs
  wire wr_instr = wr_take && (i_awaddr == REG_INSTR) && !busy;
  wire wr_loc = wr_take && (i_awaddr == REG_LOC) && !busy;
  wire wr_ja = wr_take && (i_awaddr == REG_JA) && !busy;
  wire wr_stat = wr_take && (i_awaddr == REG_STATUS);
  wire wr_ro = wr_take && (i_awaddr == REG_DECODE);
  wire wr_ok = wr_instr || wr_loc || wr_ja || wr_stat || wr_ro;
  wire [31:0] instr_word = {7'h00, pos_reg, instr_reg};
  wire [31:0] ja_word = {15'h0000, ja_f_reg, 16'(ja_addr_reg)};
  wire [31:0] loc_word = 32'(loc_reg);
  wire [31:0] instr_wr = merge32(instr_word, i_wdata, i_wstrb);
  wire [31:0] loc_wr = merge32(loc_word, i_wdata, i_wstrb);
  wire [31:0] ja_wr = merge32(ja_word, i_wdata, i_wstrb);
  wire [31:0] status_word = {30'h00000000, done_reg, busy};
  wire [31:0] decode_word = {7'h00, indexable, mode_ignored, is_ext,
    index_right, jump_right, float_mode, rpt_pair, active_mode,
    right_mode, left_mode, rpt_count};
  wire rd_hit = (i_araddr == REG_INSTR) || (i_araddr == REG_LOC) ||
    (i_araddr == REG_JA) || (i_araddr == REG_STATUS) ||
    (i_araddr == REG_DECODE);
  wire [31:0] rd_mux =
    (i_araddr == REG_INSTR) ? instr_word :
    (i_araddr == REG_LOC) ? loc_word :
    (i_araddr == REG_JA) ? ja_word :
    (i_araddr == REG_STATUS) ? status_word :
    (i_araddr == REG_DECODE) ? decode_word : 32'h00000000;

  assign o_awready = wr_take;
  assign o_wready = wr_take;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign o_arready = rd_take;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;

  // ----------------------------------------------------------------
  // jump register and sequence control
  // ----------------------------------------------------------------
  wire idle_start = (state_reg == ST_IDLE) && start_reg;
  wire load_jump = idle_start && is_jmp;
  wire load_tij = idle_start && is_tij;
  wire finish = (idle_start && !mem_op) ||
    ((state_reg == ST_WRITE) && i_mem_ack);
  // RULE6: flag names the half run when no jump
  wire [ADDR_W-1:0] jump_link = pos_reg ? loc_reg + ADDR_W'(1) : loc_reg;
  // RULE13: incremented address lands in the jump register first
  assign ja_addr_next = wr_ja ? ja_wr[ADDR_W-1:0] :
    load_jump ? jump_link :
    load_tij ? own_addr :
    (state_reg == ST_INCR) ? inc_field : ja_addr_reg;
  // RULE7: own flag copied
  assign ja_f_next = wr_ja ? ja_wr[JA_F_BIT] :
    load_jump ? !pos_reg :
    load_tij ? f_bit : ja_f_reg;
  // RULE12: merge written back over the read word
  assign oper_next =
    ((state_reg == ST_READ) && i_mem_ack) ? i_mem_rdata :
    (state_reg == ST_MERGE) ? new_word : oper_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_reg && mem_op) begin
          state_next = ST_READ;
        end
      end
      ST_READ: begin
        if (i_mem_ack) begin
          state_next = is_memory_address_increment ? ST_INCR : ST_MERGE;
        end
      end
      ST_INCR: state_next = ST_MERGE;
      ST_MERGE: state_next = ST_WRITE;
      ST_WRITE: begin
        if (i_mem_ack) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  assign o_mem_req = (state_reg == ST_READ) || (state_reg == ST_WRITE);
  assign o_mem_we = (state_reg == ST_WRITE);
  assign o_mem_addr = mem_addr_reg;
  assign o_mem_wdata = oper_reg;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_reg <= ST_IDLE;
      start_reg <= 1'b0;
      instr_reg <= '0;
      pos_reg <= 1'b0;
      loc_reg <= '0;
      ja_addr_reg <= '0;
      ja_f_reg <= 1'b0;
      oper_reg <= '0;
      mem_addr_reg <= '0;
    end else begin
      state_reg <= state_next;
      start_reg <= wr_instr;
      if (wr_instr) begin
        instr_reg <= instr_wr[HALF_W-1:0];
        pos_reg <= instr_wr[POS_BIT];
      end
      if (wr_loc) begin
        loc_reg <= loc_wr[ADDR_W-1:0];
      end
      ja_addr_reg <= ja_addr_next;
      ja_f_reg <= ja_f_next;
      oper_reg <= oper_next;
      if (idle_start) begin
        mem_addr_reg <= own_addr;
      end
    end
  end

  // done is sticky; a finish in the clearing cycle wins
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= finish ||
        (done_reg && !(wr_stat && i_wstrb[0] && i_wdata[ST_DONE_BIT]));
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else begin
      if (wr_take) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (i_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_take) begin
        rvalid_reg <= 1'b1;
        rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        rdata_reg <= rd_mux;
      end else if (i_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence memory_address_increment_read_done;
    (state_reg == ST_READ) && i_mem_ack && is_memory_address_increment;
  endsequence
  sequence memory_address_increment_tail;
    (state_reg == ST_INCR) ##1 (state_reg == ST_MERGE)
      ##1 (state_reg == ST_WRITE) && o_mem_we;
  endsequence

  a_rpt_mode_pairs: assert property ( // RULE1
    is_rpt |-> (left_mode == mod_of(instr_reg[23:22])) &&
      (right_mode == (instr_reg[21] ? (instr_reg[20] ? MOD_SUB : MOD_ADD)
      : MOD_NONE))) else $error("repeat mode decode wrong");
  a_rpt_size_bit: assert property ( // RULE2
    (is_rpt && s_bit) |-> (left_mode != MOD_NONE))
    else $error("repeat a bit not size select");
  a_tjm_reduced_field: assert property ( // RULE3
    ((state_reg == ST_MERGE) && is_tjm && tgt_half[S_BIT]) |=>
      (tgt_addr[ADDR_W-1:V_W] == $past(tgt_addr[ADDR_W-1:V_W])) &&
      (tgt_addr[V_W-1:0] == $past(ja_addr_reg[V_W-1:0])))
    else $error("reduced substitution wrong");
  a_tjm_full_field: assert property ( // RULE3
    ((state_reg == ST_MERGE) && is_tjm && !tgt_half[S_BIT]) |=>
      (tgt_addr == $past(ja_addr_reg))) else $error("full subst wrong");
  a_rpt_count_limit: assert property ( // RULE4
    is_rpt |-> (rpt_count <= RPT_MAX) && (decode_word[11:0] == rpt_count))
    else $error("repeat count field wrong");
  a_tjm_flag_copy: assert property ( // RULE5
    ((state_reg == ST_MERGE) && is_tjm) |=>
      (tgt_half[F_BIT] == $past(ja_f_reg))) else $error("flag not copied");
  a_jump_next_half: assert property ( // RULE6
    load_jump |=> (ja_f_reg == !$past(pos_reg)))
    else $error("jump flag wrong");
  a_tij_flag_copy: assert property ( // RULE7
    load_tij |=> (ja_f_reg == $past(f_bit))) else $error("tij flag wrong");
  a_float_select: assert property ( // RULE8
    is_arith |-> (decode_word[19] == f_bit)) else $error("number format");
  a_memory_address_increment_sequence: assert property ( // RULE13
    memory_address_increment_read_done |=> memory_address_increment_tail) else $error("increment order wrong");
  a_memory_address_increment_plus_one: assert property ( // RULE12
    (state_reg == ST_INCR) |=>
      (ja_addr_reg == $past(inc_field)) &&
      (inc_field != tgt_addr || tgt_mask == '0))
    else $error("increment value wrong");
  a_memory_address_increment_keeps_flag: assert property ( // RULE14
    ((state_reg == ST_MERGE) && is_memory_address_increment) |=>
      (oper_reg[F_BIT] == $past(oper_reg[F_BIT])) &&
      (oper_reg[HALF_W+F_BIT] == $past(oper_reg[HALF_W+F_BIT])))
    else $error("increment changed flag");
  a_rpt_not_indexed: assert property ( // RULE16
    is_rpt |-> !decode_word[24]) else $error("repeat marked indexable");
endmodule

// [dv/core_memory_model.sv]
// behavioural core memory answering the modifier's word requests
module core_memory_model (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [14:0] i_addr,
  input wire logic [47:0] i_wdata,
  input wire logic [7:0] i_delay,
  output logic [47:0] o_rdata,
  output logic o_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // storage and answer timing
  // ----------------------------------------------------------------
  // only five address bits decode: a small window keeps the model short
  logic [47:0] mem [32];
  logic [7:0] cnt = 8'h0;
  initial o_ack = 1'b0;
  initial o_rdata = 48'h0;
  // read data toggles outside an answer so stale words never look valid
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack) begin
      cnt <= cnt + 8'h1;
      if (cnt >= i_delay) begin
        cnt <= 8'h0;
        o_ack <= 1'b1;
        if (i_we) mem[i_addr[4:0]] <= i_wdata;
        else o_rdata <= mem[i_addr[4:0]];
      end
    end
  end
endmodule

// [dv/instruction_address_modify_tb.sv]
// self-checking bench for the instruction address modifier
module instruction_address_modify_tb;
  import instr_modify_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals, instances and watchdog
  // ----------------------------------------------------------------
  logic clk = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0, mdly = 8'h0;
  logic [31:0] wdata = 32'h0, seed = 32'h5c638ece;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, mreq, mwe, mack;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [14:0] maddr;
  logic [47:0] mwdata, mrdata;
  logic [7:0] lc [8] = '{8'h0a, 8'h02, 8'h0c, 8'h00, 8'h10, 8'h78, 8'h79,
    8'h7a};
  int err_count = 0, compares = 0, cyc = 0;
  always #5 clk = ~clk;
  instruction_address_modify instruction_address_modify_i (
    .i_clk(clk), .i_nrst(nrst), .i_awvalid(awvalid), .o_awready(awready),
    .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
    .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
    .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
    .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
    .o_rdata(rdata), .o_rresp(rresp), .o_mem_req(mreq), .o_mem_we(mwe),
    .o_mem_addr(maddr), .o_mem_wdata(mwdata), .i_mem_rdata(mrdata),
    .i_mem_ack(mack));
  core_memory_model core_memory_model_i (
    .i_clk(clk), .i_req(mreq), .i_we(mwe), .i_addr(maddr),
    .i_wdata(mwdata), .i_delay(mdly), .o_rdata(mrdata), .o_ack(mack));
  // a hung handshake ends the run here rather than never
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // helpers and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
    return seed;
  endfunction
  function automatic logic [23:0] hw(logic s, logic [5:0] op, logic f,
                                     logic [14:0] a);
    return {s, op, f, 1'b0, a};
  endfunction
  function automatic logic [31:0] mk(logic p, logic [23:0] h);
    return {7'h0, p, h};
  endfunction
  // new address field into one half, width picked by that half's S bit
  function automatic logic [47:0] put(logic [47:0] w, logic h,
                                      logic [14:0] v, logic f);
    logic [23:0] x;
    x = h ? w[23:0] : w[47:24];
    if (x[S_BIT]) x[11:0] = v[11:0];
    else x[14:0] = v;
    x[F_BIT] = f;
    return h ? {w[47:24], x} : {x, w[23:0]};
  endfunction
  function automatic logic [31:0] dec(logic [23:0] h, logic p);
    logic [5:0] c;
    logic [1:0] ml, mr;
    c = h[CMD_HI:CMD_LO];
    ml = h[23] ? (h[22] ? MOD_SUB : MOD_ADD) : MOD_NONE;
    mr = h[21] ? (h[20] ? MOD_SUB : MOD_ADD) : MOD_NONE;
    return {7'h0, c[2:0] != RPT_LOW3,
      c[2:0] == RPT_LOW3 || c == OP_NOP || c == OP_HLT,
      h[23:16] == OP_EXT_INS || h[23:16] == OP_EXT_CLR,
      c == OP_INDEX && h[F_BIT], c == OP_JMP && h[F_BIT],
      c == OP_ARITH && h[F_BIT], p, p ? mr : ml, mr, ml, h[11:0]};
  endfunction
  task automatic chk(input logic [47:0] got, exp, input string m);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_mem(input logic [4:0] a, input logic [47:0] e);
    chk(core_memory_model_i.mem[a], e, "memory word");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({46'h0, bresp}, {46'h0, er}, "write resp");
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, m,
                      input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk({16'h0, d & m}, {16'h0, e & m}, "read data");
    chk({46'h0, r}, {46'h0, er}, "read resp");
  endtask
  task automatic fin();
    logic [31:0] d;
    logic [1:0] r;
    do rd(REG_STATUS, d, r); while (d[ST_BUSY_BIT] !== 1'b0);
    chk({46'h0, d[1:0]}, 48'h2, "done flag");
    wr(REG_STATUS, 32'h2, RESP_OKAY);
    rchk(REG_STATUS, 32'h0, '1, RESP_OKAY);
  endtask
  task automatic run(input logic [31:0] i);
    wr(REG_INSTR, i, RESP_OKAY);
    fin();
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [47:0] w;
    logic [23:0] h;
    logic [14:0] a;
    logic [4:0] l;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++) rchk(8'(4 * i), 32'h0, '1, RESP_OKAY);
    rchk(8'h14, 32'h0, '1, RESP_SLVERR);
    wr(8'h14, rnd(), RESP_SLVERR);
    $display("test reset and map done");
    for (int k = 0; k < 2; k++) begin
      r = rnd();
      wr(REG_LOC, {17'h0, r[14:0]}, RESP_OKAY);
      run(mk(k[0], hw(1'b0, OP_JMP, r[16], r[30:16])));
      a = r[14:0] + 15'(k);
      rchk(REG_JA, {15'h0, !k[0], 1'b0, a}, '1, RESP_OKAY); // next half
    end
    $display("test jump done");
    for (int k = 0; k < 6; k++) begin
      r = rnd();
      a = r[30:16];
      run(mk(r[4], hw(r[0], OP_TIJ, r[1], a)));
      if (r[0]) a[14:12] = 3'h0;
      rchk(REG_JA, {15'h0, r[1], 1'b0, a}, '1, RESP_OKAY); // own flag
      l = r[9:5];
      w = {rnd(), 16'(rnd())};
      core_memory_model_i.mem[l] = w;
      run(mk(1'b0, hw(1'b0, OP_TJM, r[2], {10'h0, l})));
      chk_mem(l, put(w, r[2], a, r[1])); // width and flag
    end
    $display("test substitute done");
    // last pass answers slowly so a write lands while busy
    for (int k = 0; k < 6; k++) begin
      r = rnd();
      l = r[9:5];
      w = {rnd(), 16'(rnd())};
      if (k < 2) w[38:24] = 15'h7fff;
      if (k < 2) w[14:0] = 15'h7fff;
      mdly <= (k == 5) ? 8'h14 : {6'h0, r[13:12]};
      h = r[0] ? w[23:0] : w[47:24];
      a = h[S_BIT] ? {3'h0, h[11:0] + 12'h1} : h[14:0] + 15'h1;
      core_memory_model_i.mem[l] = w;
      wr(REG_INSTR, mk(1'b0, hw(1'b0, OP_MEMORY_ADDRESS_INCREMENT, r[0], {10'h0, l})),
        RESP_OKAY);
      if (k == 5) wr(REG_JA, 32'h0, RESP_SLVERR);
      fin();
      chk_mem(l, put(w, r[0], a, h[F_BIT])); // field
      rchk(REG_JA, {17'h0, a}, 32'h7fff, RESP_OKAY); // via jump reg
    end
    $display("test increment done");
    for (int k = 0; k < 16; k++) begin
      r = rnd();
      h = {k[3:0], RPT_LOW3, r[16], 1'b0, r[14:0]};
      if (k == 15) h[11:0] = RPT_MAX;
      run(mk(r[20], h));
      rchk(REG_DECODE, dec(h, r[20]), 32'h1ffffff, RESP_OKAY);
    end
    $display("test repeat decode done");
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      h = {lc[k] | {7'h0, k < 5 && r[0]}, 1'b0, r[30:16]};
      run(mk(r[8], h));
      rchk(REG_DECODE, dec(h, r[8]), 32'hf80000, RESP_OKAY);
    end
    $display("test class decode done");
    give_verdict();
  end
endmodule
